// ### fpp_regs.svh
// Purpose: constants for the fault pin propagation block
// Assumes: one word per channel, reached by command code
// Notes:   definitions only
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH
`define FPP_CMD_PROPAGATE   8'hd2
`define FPP_CMD_PIN_RESP    8'hd5
`define FPP_MASK_RESET      16'h6993
`define FPP_RESP_INHIBIT    8'hc0
`define FPP_RESP_IGNORE     8'h00
`define FPP_BIT_DECAY       15
`define FPP_BIT_SHORT       14
`define FPP_BIT_TON         13
`define FPP_BIT_RAW_UV      12
`define FPP_BIT_INT_OT      11
`define FPP_BIT_CH1_GOOD    10
`define FPP_NUM_CH          2
`endif

// ### fpp_pkg.sv
// Purpose: types for the fault pin propagation block
// Assumes: two channels
// Notes:   state carried as one packed struct
package fpp_pkg;
   typedef struct packed {
      logic decay_wait;    // restart withheld awaiting decay
      logic short_off;     // off after short-cycle event
      logic ton_fault;     // turn-on timeout fault
      logic raw_uv;        // unfiltered undervoltage comparator
      logic ton_respond;   // response setting acts on timeout
   } fpp_cond_s;
   typedef struct packed {
      logic [1:0][15:0] mask;
      logic [1:0][7:0]  pin_resp;
      logic [7:0]       rdata;
      logic [1:0]       pull_low;
   } fpp_state_s;
endpackage : fpp_pkg

// ### fpp_fault_pin.sv
// Purpose: per-channel fault propagation onto shared fault pins
// Assumes: command decode done upstream; inputs synchronous to mclk
// Notes:   pins open-drain, oe low while driving low
//
// Overview of operation
// - paged 16-bit word at 0xd2, reset 0x6993
// - set bit drives pin low on condition
// - turn-on timeout propagates only if response acts
// - common and per-channel events share pins
// - multiphase restart withheld until 12.5% decay
// - bit 15 propagates decay wait
// - bit 14 propagates short-cycle off
// - bit 13 propagates turn-on timeout
// - bit 12 propagates raw undervoltage comparator
// - bit 11 propagates internal overtemperature
// - bit 10 propagates channel 1 not good
// - host sets pin response ignore with bit 10
// - external low inhibits output if 0xc0
`include "fpp_regs.svh"
module fpp_fault_pin
   import fpp_pkg::*;
(
   input  wire logic             mclk,          // 25 MHz clock
   input  wire logic             sys_rst,       // async reset, high
   input  wire logic             cmd_wr,        // write strobe
   input  wire logic             cmd_rd,        // read strobe
   input  wire logic [7:0]       cmd_code,      // command code
   input  wire logic             cmd_page,      // selected page
   input  wire logic             cmd_hi,        // high data byte
   input  wire logic [7:0]       cmd_wdata,     // write byte
   output logic      [7:0]       cmd_rdata,     // read byte
   input  fpp_cond_s [1:0]       ch_cond,       // per-channel conditions
   input  wire logic             int_ot,        // internal overtemp
   input  wire logic             ch1_good,      // channel 1 power good
   input  wire logic [1:0]       pin_in,        // fault pin level
   output logic      [1:0]       pin_out,       // fault pin drive value
   output logic      [1:0]       pin_oe_n,      // low while pulling low
   output logic      [1:0]       out_inhibit    // three-state outputs
);
   fpp_state_s st_reg;
   fpp_state_s st_next;
   logic [1:0] cause;

   // -----------------------------------------------------------------
   // condition gathering
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `FPP_NUM_CH; g++) begin : g_ch
         always_comb begin
            cause[g] = 1'b0;
            if (st_reg.mask[g][`FPP_BIT_DECAY] && ch_cond[g].decay_wait)
               cause[g] = 1'b1;
            if (st_reg.mask[g][`FPP_BIT_SHORT] && ch_cond[g].short_off)
               cause[g] = 1'b1;
            // timeout only counts when its response shuts down
            if (st_reg.mask[g][`FPP_BIT_TON] && ch_cond[g].ton_fault
                && ch_cond[g].ton_respond)
               cause[g] = 1'b1;
            if (st_reg.mask[g][`FPP_BIT_RAW_UV] && ch_cond[g].raw_uv)
               cause[g] = 1'b1;
            if (st_reg.mask[g][`FPP_BIT_INT_OT] && int_ot)
               cause[g] = 1'b1;
            if (st_reg.mask[g][`FPP_BIT_CH1_GOOD] && !ch1_good)
               cause[g] = 1'b1;
         end
         // self-pull would latch off unless response is ignore
         assign out_inhibit[g] = !pin_in[g] && !st_reg.pull_low[g]
            && (st_reg.pin_resp[g] == `FPP_RESP_INHIBIT);
      end
   endgenerate

   // -----------------------------------------------------------------
   // register file and pin state
   // -----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.pull_low = cause;
      if (cmd_wr && cmd_code == `FPP_CMD_PROPAGATE) begin
         if (cmd_hi)
            st_next.mask[cmd_page][15:8] = cmd_wdata;
         else
            st_next.mask[cmd_page][7:0] = cmd_wdata;
      end
      if (cmd_wr && cmd_code == `FPP_CMD_PIN_RESP)
         st_next.pin_resp[cmd_page] = cmd_wdata;
      if (cmd_rd) begin
         if (cmd_code == `FPP_CMD_PROPAGATE)
            st_next.rdata = cmd_hi ? st_reg.mask[cmd_page][15:8]
                                   : st_reg.mask[cmd_page][7:0];
         else if (cmd_code == `FPP_CMD_PIN_RESP)
            st_next.rdata = st_reg.pin_resp[cmd_page];
         else
            st_next.rdata = 8'h00;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg.mask     <= {`FPP_MASK_RESET, `FPP_MASK_RESET};
         st_reg.pin_resp <= {`FPP_RESP_INHIBIT, `FPP_RESP_INHIBIT};
         st_reg.rdata    <= 8'h00;
         st_reg.pull_low <= 2'h0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cmd_rdata = st_reg.rdata;
   assign pin_out   = 2'h0;
   assign pin_oe_n  = ~st_reg.pull_low;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_ot_pull;
      @(posedge mclk) disable iff (sys_rst)
      (int_ot && st_reg.mask[0][`FPP_BIT_INT_OT]) |=> !pin_oe_n[0];
   endproperty
   a_ot_pull: assert property (p_ot_pull)
      else $error("overtemp did not pull pin 0");

   property p_good_pull;
      @(posedge mclk) disable iff (sys_rst)
      (!ch1_good && st_reg.mask[1][`FPP_BIT_CH1_GOOD]) |=> !pin_oe_n[1];
   endproperty
   a_good_pull: assert property (p_good_pull)
      else $error("ch1 not good did not pull pin 1");

   property p_uv_pull;
      @(posedge mclk) disable iff (sys_rst)
      (ch_cond[0].raw_uv && st_reg.mask[0][`FPP_BIT_RAW_UV])
      |=> !pin_oe_n[0];
   endproperty
   a_uv_pull: assert property (p_uv_pull)
      else $error("raw uv did not pull pin 0");

   property p_ton_gate;
      @(posedge mclk) disable iff (sys_rst)
      (ch_cond[1] == 5'b00100 && !int_ot && ch1_good) |=> pin_oe_n[1];
   endproperty
   a_ton_gate: assert property (p_ton_gate)
      else $error("ignored timeout reached pin 1");

   property p_short_pull;
      @(posedge mclk) disable iff (sys_rst)
      (ch_cond[1].short_off && st_reg.mask[1][`FPP_BIT_SHORT])
      |=> !pin_oe_n[1];
   endproperty
   a_short_pull: assert property (p_short_pull)
      else $error("short cycle did not pull pin 1");

   property p_decay_pull;
      @(posedge mclk) disable iff (sys_rst)
      (ch_cond[0].decay_wait && st_reg.mask[0][`FPP_BIT_DECAY])
      |=> !pin_oe_n[0];
   endproperty
   a_decay_pull: assert property (p_decay_pull)
      else $error("decay wait did not pull pin 0");

   property p_mask_write;
      @(posedge mclk) disable iff (sys_rst)
      (cmd_wr && cmd_code == `FPP_CMD_PROPAGATE && !cmd_hi && !cmd_page)
      |=> st_reg.mask[0][7:0] == $past(cmd_wdata);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask low byte not stored");

   property p_no_cause;
      @(posedge mclk) disable iff (sys_rst)
      (cause == 2'h0) |=> (pin_oe_n == 2'h3);
   endproperty
   a_no_cause: assert property (p_no_cause)
      else $error("pin pulled with no enabled cause");

   property p_inhibit;
      @(posedge mclk) disable iff (sys_rst)
      (st_reg.pin_resp[0] == `FPP_RESP_IGNORE) |-> !out_inhibit[0];
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("inhibit while response is ignore");
endmodule : fpp_fault_pin

// ### fpp_peer.sv
// Purpose: peer controller sharing the fault pins
// Assumes: pull-up on each pin
// Notes:   pin is the wired-and of all parties
module fpp_peer (
   input  wire logic [1:0] pin_oe_n,  // design pulls low when 0
   input  wire logic [1:0] peer_pull, // peer pulls low when 1
   output logic      [1:0] pin_lvl    // resolved pin level
);
   timeunit 1ns;
   timeprecision 1ns;
   // released pin goes to the pull-up level, never the last value
   assign pin_lvl = pin_oe_n & ~peer_pull;
endmodule : fpp_peer

// ### testbench.sv
// Purpose: self-checking bench for the fault pin propagation block
// Assumes: seed 67, peer model resolves the shared pins
// Notes:   conditions held two edges before pins are judged
`include "fpp_regs.svh"
module testbench;
   import fpp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic             mclk = 0, sys_rst = 1, cmd_wr = 0, cmd_rd = 0;
   logic             cmd_page = 0, cmd_hi = 0, int_ot = 0, ch1_good = 1;
   logic [7:0]       cmd_code = 0, cmd_wdata = 0, cmd_rdata;
   logic [1:0]       pin_lvl, pin_out, pin_oe_n, out_inhibit, peer_pull = 0;
   fpp_cond_s [1:0]  ch_cond = '0;
   logic [1:0][15:0] mdl = {2{`FPP_MASK_RESET}};
   logic [1:0][7:0]  rsp = {2{`FPP_RESP_INHIBIT}};
   logic [15:0]      m;
   logic             pg;
   int               miscompares = 0, comparisons = 0;
   always #20 mclk = ~mclk;
   fpp_fault_pin u_dut (.mclk, .sys_rst, .cmd_wr, .cmd_rd, .cmd_code,
      .cmd_page, .cmd_hi, .cmd_wdata, .cmd_rdata, .ch_cond, .int_ot,
      .ch1_good, .pin_in(pin_lvl), .pin_out, .pin_oe_n, .out_inhibit);
   fpp_peer u_peer (.pin_oe_n, .peer_pull, .pin_lvl);
   function automatic logic [1:0] exp_pull(input fpp_cond_s [1:0] c,
                                           input logic ot, g);
      for (int i = 0; i < 2; i++)
         exp_pull[i] = |(mdl[i][15:10] & {c[i].decay_wait, c[i].short_off,
            c[i].ton_fault & c[i].ton_respond, c[i].raw_uv, ot, !g});
   endfunction : exp_pull
   task automatic chk(input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task automatic op(input logic w, input logic [7:0] c, input logic p, h,
                     input logic [7:0] d);
      @(posedge mclk);
      cmd_wr    <= w;
      cmd_rd    <= !w;
      cmd_code  <= c;
      cmd_page  <= p;
      cmd_hi    <= h;
      cmd_wdata <= d;
      @(posedge mclk);
      cmd_wr    <= 0;
      cmd_rd    <= 0;
      #1;
   endtask : op
   task automatic rdall;
      for (int p = 0; p < 2; p++) begin
         op(0, `FPP_CMD_PROPAGATE, p[0], 0, 0);
         chk(mdl[p][7:0], cmd_rdata);
         op(0, `FPP_CMD_PROPAGATE, p[0], 1, 0);
         chk(mdl[p][15:8], cmd_rdata);
         op(0, `FPP_CMD_PIN_RESP, p[0], 0, 0);
         chk(rsp[p], cmd_rdata);
      end
   endtask : rdall
   task automatic pins(input fpp_cond_s [1:0] c, input logic ot, g,
                       input logic [1:0] pp);
      logic [1:0] e;
      e = exp_pull(c, ot, g);
      @(posedge mclk);
      ch_cond   <= c;
      int_ot    <= ot;
      ch1_good  <= g;
      peer_pull <= pp;
      repeat (2) @(posedge mclk);
      #1;
      chk(2'(~e), pin_oe_n);
      chk(2'h0, pin_out);
      chk({rsp[1] == 8'hc0, rsp[0] == 8'hc0} & pp & ~e, out_inhibit);
   endtask : pins
   task automatic wrap_up;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial begin
      #400000;
      miscompares++;
      wrap_up();
   end
   initial begin
      void'($urandom(67));
      repeat (4) @(posedge mclk);
      sys_rst <= 0;
      rdall();
      op(1, 8'h01, 0, 1, 8'h00);
      op(0, 8'h01, 0, 0, 8'h00);
      chk(0, cmd_rdata);
      rdall();
      $display("test registers done");
      mdl = '0;
      op(1, `FPP_CMD_PROPAGATE, 0, 1, 8'h00);
      op(1, `FPP_CMD_PROPAGATE, 1, 1, 8'h00);
      pins('1, 1, 0, 2'b00);
      mdl = '1;
      for (int p = 0; p < 2; p++) begin
         op(1, `FPP_CMD_PROPAGATE, p[0], 1, 8'hff);
         op(1, `FPP_CMD_PROPAGATE, p[0], 0, 8'hff);
      end
      pins({2{5'b00100}}, 0, 1, 2'b11);
      pins({5'b00001, 5'b00000}, 0, 0, 2'b00);
      $display("test corners done");
      repeat (60) begin
         m = 16'($urandom);
         pg = 1'($urandom);
         mdl[pg] = m;
         rsp[pg] = $urandom % 2 ? `FPP_RESP_INHIBIT : `FPP_RESP_IGNORE;
         // host keeps ignore while channel 1 good propagates
         if (m[`FPP_BIT_CH1_GOOD])
            rsp[pg] = `FPP_RESP_IGNORE;
         op(1, `FPP_CMD_PROPAGATE, pg, 0, m[7:0]);
         op(1, `FPP_CMD_PROPAGATE, pg, 1, m[15:8]);
         op(1, `FPP_CMD_PIN_RESP, pg, 0, rsp[pg]);
         pins(10'($urandom), 1'($urandom), 1'($urandom), 2'($urandom));
      end
      rdall();
      $display("test random done");
      wrap_up();
   end
endmodule : testbench
